/* oag_defines.svh */
// Constants for the operand address generator.
`ifndef OAG_DEFINES_SVH
`define OAG_DEFINES_SVH
`define OAG_SHORT_BASE 8'hFE
`define OAG_SHORT_LOW_LIMIT 8'h20
`define OAG_PERIPH_UPPER 8'hFF
`define OAG_PERIPH_HOLE_HI 4'hD
`define OAG_RAM_FIRST 16'hFE20
`define OAG_RAM_LAST 16'hFEFF
`define OAG_SFR_SHORT_FIRST 16'hFF00
`define OAG_SFR_SHORT_LAST 16'hFF1F
`define OAG_RESET_ADDR 16'h0000
`define OAG_RESET_BANK 4'h0
`define OAG_RESET_BYTE 8'h00
`endif

/* oag_pkg.sv */
// Types for the operand address generator.
package oag_pkg;
    typedef enum logic [2:0] {
        OAG_MODE_DIRECT = 3'h0,
        OAG_MODE_SHORT = 3'h1,
        OAG_MODE_PERIPH = 3'h2,
        OAG_MODE_INDIRECT = 3'h3,
        OAG_MODE_BASED = 3'h4,
        OAG_MODE_INDEXED = 3'h5,
        OAG_MODE_STACK = 3'h6,
        OAG_MODE_NONE = 3'h7
    } oag_mode_t;

    typedef enum logic [1:0] {
        OAG_AREA_OTHER = 2'h0,
        OAG_AREA_RAM = 2'h1,
        OAG_AREA_SFR = 2'h2
    } oag_area_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [3:0] bank;
        logic banked;
        logic [1:0] area;
        logic valid;
        logic fault;
        logic [7:0] reg_data;
    } oag_state_t;
endpackage

/* oag_reg_select.sv */
// Picks one 8-bit general register from the active bank.
`timescale 1ns/1ns
module oag_reg_select
    import oag_pkg::*;
(
    // Register file contents, four banks of eight bytes.
    input wire logic [255:0] reg_file_in,
    // Selection.
    input wire logic register_bank_select_low_in,
    input wire logic register_bank_select_high_in,
    input wire logic [2:0] reg_code_in,
    // Selected byte.
    output logic [7:0] reg_data_out
);
    logic [4:0] index;

    // Bank flags form the upper index bits, opcode code the lower ones.
    always_comb begin
        index = {register_bank_select_high_in, register_bank_select_low_in, reg_code_in};
        reg_data_out = reg_file_in[{index, 3'h0} +: 8];
    end
endmodule

/* oag_top.sv */
// Operand effective-address generator for the processor core.
`timescale 1ns/1ns
`include "oag_defines.svh"
module oag_top
    import oag_pkg::*;
(
    // Clock and reset.
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    // Request from decode.
    input wire logic req_in,
    input wire logic [2:0] mode_in,
    input wire logic word_in,
    input wire logic word_capable_in,
    input wire logic [15:0] long_immediate_operand_in,
    input wire logic [7:0] byte_field_in,
    input wire logic pair_code_in,
    input wire logic index_code_in,
    input wire logic [2:0] reg_code_in,
    // Register bank contents and machine state.
    input wire logic [255:0] reg_file_in,
    input wire logic register_bank_select_low_in,
    input wire logic register_bank_select_high_in,
    input wire logic [15:0] stack_pointer_in,
    input wire logic [3:0] memory_bank_in,
    // Address answer.
    output logic addr_valid_out,
    output logic [15:0] addr_out,
    output logic [3:0] bank_out,
    output logic banked_out,
    output logic [1:0] area_out,
    output logic fault_out,
    output logic [7:0] reg_data_out
);
    oag_state_t state;
    oag_state_t next_state;
    logic [7:0] sel_byte;
    logic [15:0] pair_one;
    logic [15:0] base_pair;
    logic [7:0] index_byte;
    logic [4:0] bank_base;
    logic [15:0] ea;
    logic fault;
    logic banked;

    // Register operand selector for the active bank.
    oag_reg_select u_reg_select (
        .reg_file_in(reg_file_in),
        .register_bank_select_low_in(register_bank_select_low_in),
        .register_bank_select_high_in(register_bank_select_high_in),
        .reg_code_in(reg_code_in),
        .reg_data_out(sel_byte)
    );

    // Pairs of the active bank: byte 0 X, 1 A, 2 C, 3 B, 4 E, 5 D, 6 L, 7 H.
    always_comb begin
        bank_base = {register_bank_select_high_in, register_bank_select_low_in, 3'h0};
        pair_one = {reg_file_in[{bank_base + 5'h5, 3'h0} +: 8], reg_file_in[{bank_base + 5'h4, 3'h0} +: 8]};
        base_pair = {reg_file_in[{bank_base + 5'h7, 3'h0} +: 8], reg_file_in[{bank_base + 5'h6, 3'h0} +: 8]};
        if (index_code_in) begin
            index_byte = reg_file_in[{bank_base + 5'h3, 3'h0} +: 8];
        end else begin
            index_byte = reg_file_in[{bank_base + 5'h2, 3'h0} +: 8];
        end
    end

    // Effective address per mode, plus fault flag for misuse.
    always_comb begin
        ea = `OAG_RESET_ADDR;
        fault = 1'b0;
        banked = 1'b0;
        case (oag_mode_t'(mode_in))
            OAG_MODE_DIRECT: begin
                ea = long_immediate_operand_in;
                banked = 1'b1;
            end
            OAG_MODE_SHORT: begin
                // Bit 8 is the inverse of "field at or above 20H".
                ea = {7'h7F, (byte_field_in < `OAG_SHORT_LOW_LIMIT), byte_field_in};
                fault = word_in & byte_field_in[0];
            end
            OAG_MODE_PERIPH: begin
                ea = {`OAG_PERIPH_UPPER, byte_field_in};
                // FFD0H-FFDFH is not reachable, odd or incapable word access refused.
                fault = (byte_field_in[7:4] == `OAG_PERIPH_HOLE_HI)
                    | (word_in & (byte_field_in[0] | ~word_capable_in));
            end
            OAG_MODE_INDIRECT: begin
                ea = pair_code_in ? base_pair : pair_one;
                banked = 1'b1;
            end
            OAG_MODE_BASED: begin
                ea = base_pair + {8'h00, byte_field_in};
                banked = 1'b1;
            end
            OAG_MODE_INDEXED: begin
                ea = base_pair + {8'h00, index_byte};
                banked = 1'b1;
            end
            OAG_MODE_STACK: begin
                ea = stack_pointer_in;
                // Stack outside high-speed RAM is flagged.
                fault = (stack_pointer_in < `OAG_RAM_FIRST) | (stack_pointer_in > `OAG_RAM_LAST);
            end
            default: begin
                fault = 1'b1;
            end
        endcase
    end

    // Next-state assembly, including area decode of the address.
    always_comb begin
        next_state = state;
        next_state.valid = req_in;
        if (req_in) begin
            next_state.addr = ea;
            next_state.fault = fault;
            next_state.banked = banked;
            next_state.bank = banked ? memory_bank_in : `OAG_RESET_BANK;
            next_state.reg_data = sel_byte;
            if (ea >= `OAG_RAM_FIRST && ea <= `OAG_RAM_LAST) begin
                next_state.area = OAG_AREA_RAM;
            end else if (ea >= `OAG_SFR_SHORT_FIRST) begin
                next_state.area = OAG_AREA_SFR;
            end else begin
                next_state.area = OAG_AREA_OTHER;
            end
        end
    end

    // State register.
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state <= '{addr: `OAG_RESET_ADDR, bank: `OAG_RESET_BANK, banked: 1'b0, area: 2'h0,
                       valid: 1'b0, fault: 1'b0, reg_data: `OAG_RESET_BYTE};
        end else begin
            state <= next_state;
        end
    end

    // Outputs straight from the state flip-flops.
    always_comb begin
        addr_valid_out = state.valid;
        addr_out = state.addr;
        bank_out = state.bank;
        banked_out = state.banked;
        area_out = state.area;
        fault_out = state.fault;
        reg_data_out = state.reg_data;
    end
endmodule

/* oag_core_model.sv */
// Core-side register bank model.
`timescale 1ns/1ns
module oag_core_model (
    output logic [255:0] reg_file_out
);
    // Byte n of the banks holds E0H plus n.
    always_comb for (int n = 0; n < 32; n++) reg_file_out[8 * n +: 8] = 8'hE0 + 8'(n);
endmodule

/* oag_checker.sv */
// Generator port assertions.
`timescale 1ns/1ns
module oag_checker (
    // Ports.
    input logic sys_clk_in,
    input logic rstn_in,
    input logic req_in,
    input logic [2:0] mode_in,
    input logic word_in,
    input logic [15:0] long_immediate_operand_in,
    input logic [7:0] byte_field_in,
    input logic [15:0] stack_pointer_in,
    input logic [15:0] addr_out,
    input logic [1:0] area_out,
    input logic fault_out
);
    // Per-mode request flags.
    logic [7:0] hit;
    assign hit = {7'h00, req_in} << mode_in;
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rstn_in);
    dir_addr_a: assert property (hit[0] |=> addr_out == $past(long_immediate_operand_in)) else $error("dir");
    short_addr_a: assert property (hit[1] |=> addr_out ==
        {7'h7F, $past(byte_field_in) < 8'h20, $past(byte_field_in)}) else $error("short");
    short_area_a: assert property (hit[1] |=> area_out == (addr_out[8] ? 2'h2 : 2'h1)) else $error("area");
    short_odd_a: assert property (hit[1] && word_in && byte_field_in[0] |=> fault_out) else $error("odd");
    sfr_addr_a: assert property (hit[2] |=> addr_out == {8'hFF, $past(byte_field_in)}) else $error("sfr");
    sfr_hole_a: assert property (hit[2] && byte_field_in[7:4] == 4'hD |=> fault_out) else $error("hole");
    stack_addr_a: assert property (hit[6] |=> addr_out == $past(stack_pointer_in)) else $error("sp");
    stack_ram_a: assert property (hit[6] && stack_pointer_in[15:8] != 8'hFE |=> fault_out) else $error("ram");
endmodule

/* oag_top_tb.sv */
// Bench for the operand address generator.
`timescale 1ns/1ns
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin mismatches++; \
    $display("FAIL %0t %h %h", $time, a, b); end end
module oag_top_tb;
    logic sys_clk_in = 1'b0, rstn_in = 1'b0, req_in = 1'b0, word_in = 1'b0, word_capable_in = 1'b0;
    logic pair_code_in = 1'b0, index_code_in = 1'b0, register_bank_select_low_in = 1'b1;
    logic register_bank_select_high_in = 1'b1, addr_valid_out, banked_out, fault_out;
    logic [2:0] mode_in = 3'h0, reg_code_in = 3'h3;
    logic [7:0] byte_field_in = 8'h00, reg_data_out;
    logic [15:0] long_immediate_operand_in = 16'h0000, stack_pointer_in = 16'hFF00, addr_out;
    logic [3:0] memory_bank_in = 4'h9, bank_out;
    logic [255:0] reg_file_in;
    logic [1:0] area_out;
    int mismatches = 0, samples_checked = 0;
    oag_top i_dut (.*);
    oag_core_model i_core (.reg_file_out(reg_file_in));
    // Free-running clock.
    initial forever #4 sys_clk_in = ~sys_clk_in;
    // One request and its registered answer.
    task automatic ask(input logic [2:0] m, input logic [7:0] f, input logic [16:0] e);
        @(posedge sys_clk_in);
        {req_in, mode_in, byte_field_in} <= {1'b1, m, f};
        @(posedge sys_clk_in);
        req_in <= 1'b0;
        #1;
        `CHK({addr_valid_out, fault_out, addr_out}, {1'b1, e})
    endtask
    task automatic t_fixed;
        long_immediate_operand_in <= 16'hA5C3;
        ask(3'h0, 8'h00, 17'h0A5C3);
        `CHK({bank_out, banked_out}, 5'h13)
        `CHK(area_out, 2'h0)
        ask(3'h1, 8'h1F, 17'h0FF1F);
        ask(3'h1, 8'h20, 17'h0FE20);
        `CHK(area_out, 2'h1)
        ask(3'h2, 8'hD0, 17'h1FFD0);
        word_in <= 1'b1;
        ask(3'h1, 8'h21, 17'h1FE21);
        ask(3'h2, 8'h40, 17'h1FF40);
        ask(3'h6, 8'h00, 17'h1FF00);
        `CHK(area_out, 2'h2)
        word_in <= 1'b0;
        // The unused mode code is flagged and leaves the address at zero.
        ask(3'h7, 8'h00, 17'h10000);
        `CHK({bank_out, banked_out, area_out}, 7'h00)
    endtask
    task automatic t_pointer;
        ask(3'h3, 8'h00, 17'h0FDFC);
        `CHK(reg_data_out, 8'hFB)
        pair_code_in <= 1'b1;
        ask(3'h3, 8'h00, 17'h0FFFE);
        ask(3'h4, 8'hFF, 17'h000FD);
        index_code_in <= 1'b1;
        ask(3'h5, 8'h00, 17'h000F9);
    endtask
    task automatic close_out;
        $display("%0d bad of %0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Reset, scenarios, verdict.
    initial begin
        repeat (2) @(posedge sys_clk_in);
        rstn_in <= 1'b1;
        t_fixed();
        t_pointer();
        close_out();
    end
    // Watchdog.
    initial begin
        #2000;
        mismatches++;
        close_out();
    end
endmodule
bind oag_top oag_checker i_chk (.*);
